/* File: window_watchdog_pkg.sv */
package window_watchdog_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR  = 8'h00;
  localparam logic [7:0] WIN_ADDR   = 8'h01;
  localparam logic [7:0] CTRL_RESET = 8'h7F;
  localparam logic [7:0] WIN_RESET  = 8'h7F;
  localparam logic [7:0] READ_NONE  = 8'h00;
  localparam int         ACT_BIT    = 7;
  localparam int         TOP_BIT    = 6;

  // ----------------------------------------------------------------
  // Counter threshold and step
  // ----------------------------------------------------------------
  localparam logic [6:0] COUNT_THRESH = 7'h40;
  localparam logic [6:0] COUNT_ONE    = 7'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TICK_CYCLES_DEF = 16384;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PULSE_NS        = 30000;
  // Typical figure, so rounded down, never below one cycle
  localparam int PULSE_CYCLES    = (PULSE_NS / CLK_PERIOD_NS < 1) ?
                                   1 : PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_W         = $clog2(PULSE_CYCLES + 1);

  // Reset pulse state
  typedef enum logic [0:0] {
    PULSE_IDLE  = 1'b0,
    PULSE_DRIVE = 1'b1
  } pulse_state_t;

  // Counter decrement, shared by logic and checks
  function automatic logic [6:0] count_dec(input logic [6:0] c);
    count_dec = c - COUNT_ONE;
  endfunction

endpackage

/* File: tick_prescaler.sv */
`timescale 1ns/1ps
module tick_prescaler
  import window_watchdog_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic clk,
  input  wire logic nrst,
  output logic      tick
);

  localparam int W = $clog2(TICK_CYCLES);
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

  logic [W-1:0] div;

  // ----------------------------------------------------------------
  // Free-running divider, one tick per period
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div == LAST);
      div  <= (div == LAST) ? '0 : div + 1'b1;
    end
  end

  // Ticks are exactly one period apart
  tick_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    tick |=> !tick ##0 (div == {{(W-1){1'b0}}, 1'b1}))
    else $error("prescaler tick period wrong");

endmodule

/* File: reset_pulse.sv */
`timescale 1ns/1ps
module reset_pulse
  import window_watchdog_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      busy
);

  pulse_state_t       state;
  logic [PULSE_W-1:0] left;
  logic [PULSE_W-1:0] low_len;

  // ----------------------------------------------------------------
  // Open-drain reset driver; starts while busy are dropped
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state    <= PULSE_IDLE;
      left     <= '0;
      pin_oe_n <= 1'b1;
      busy     <= 1'b0;
    end else begin
      case (state)
        PULSE_IDLE: begin
          if (start) begin
            state    <= PULSE_DRIVE;
            left     <= PULSE_W'(PULSE_CYCLES - 1);
            pin_oe_n <= 1'b0;
            busy     <= 1'b1;
          end
        end
        PULSE_DRIVE: begin
          if (left == '0) begin
            state    <= PULSE_IDLE;
            pin_oe_n <= 1'b1;
            busy     <= 1'b0;
          end else begin
            left <= left - 1'b1;
          end
        end
        default: begin
          state    <= PULSE_IDLE;
          pin_oe_n <= 1'b1;
          busy     <= 1'b0;
        end
      endcase
    end
  end

  // Pin only ever pulls low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pin_out <= 1'b0;
    else       pin_out <= 1'b0;
  end

  // Helper: length of the current low drive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)          low_len <= '0;
    else if (!pin_oe_n) low_len <= low_len + 1'b1;
    else                low_len <= '0;
  end

  pulse_len_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(pin_oe_n) |-> ($past(low_len) == PULSE_W'(PULSE_CYCLES - 1)))
    else $error("reset pulse length wrong");

endmodule

/* File: window_watchdog.sv */
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Count drops once per 16384-cycle tick
// - Active rollover 40h to 3Fh resets system
// - Reset pin held low about 30 us
// - Reload above window value forces reset
// - Activate bit software-set, reset-cleared, gates rollover and early-reload resets
// - Option input selects hardware or software activation
// - Hardware activation ignores the activate bit
// - Option makes halt instruction cause reset
// - Control reads activate plus count, resets 7Fh
// - Window holds seven bits, resets 7Fh
module window_watchdog
  import window_watchdog_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       opt_hw_activate,
  input  wire logic       opt_halt_reset,
  input  wire logic       halt_exec,
  output logic            rst_pin_out,
  output logic            rst_pin_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic       opt_taken;
  logic       hw_act;
  logic       halt_rst;
  logic       watchdog_activate;
  logic [6:0] count;
  logic [6:0] window;
  logic       tick;
  logic       active;
  logic       wr_ctrl;
  logic       wr_win;
  logic       early_reload;
  logic       rollover;
  logic       halt_trig;
  logic       trigger;
  logic       pulse_busy;
  logic       count_top_bit;

  // ----------------------------------------------------------------
  // Option byte capture
  // ----------------------------------------------------------------
  // Straps sampled on the first edge after release, never by reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opt_taken <= 1'b0;
      hw_act    <= 1'b0;
      halt_rst  <= 1'b0;
    end else if (!opt_taken) begin
      opt_taken <= 1'b1;
      hw_act    <= opt_hw_activate;
      halt_rst  <= opt_halt_reset;
    end
  end

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  tick_prescaler #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk  (clk),
    .nrst (nrst),
    .tick (tick)
  );

  // ----------------------------------------------------------------
  // Decode and reset causes
  // ----------------------------------------------------------------
  // Hardware option overrides the software bit
  assign active        = hw_act | watchdog_activate;
  assign wr_ctrl       = wr && (addr == CTRL_ADDR);
  assign wr_win        = wr && (addr == WIN_ADDR);
  assign count_top_bit = count[TOP_BIT];
  // Reload too soon is refused and trips a reset
  assign early_reload  = wr_ctrl && active && (count > window);
  // A reload in the same cycle as a tick wins, so no rollover
  assign rollover      = tick && active && !wr_ctrl &&
                         (count == COUNT_THRESH);
  assign halt_trig     = halt_exec && halt_rst;
  // Inactive watchdog raises nothing of its own
  assign trigger       = early_reload | rollover | halt_trig;

  // ----------------------------------------------------------------
  // Activation bit
  // ----------------------------------------------------------------
  // Set only; a written zero leaves it alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_activate <= CTRL_RESET[ACT_BIT];
    end else if (wr_ctrl && wdata[ACT_BIT]) begin
      watchdog_activate <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Downcounter
  // ----------------------------------------------------------------
  // Runs even when inactive; the timeout length is whatever
  // software loads, 7Fh down to 40h giving the usable steps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= CTRL_RESET[6:0];
    end else if (wr_ctrl && !early_reload) begin
      count <= wdata[6:0];
    end else if (tick && !wr_ctrl) begin
      count <= count_dec(count);
    end
  end

  // ----------------------------------------------------------------
  // Window register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      window <= WIN_RESET[6:0];
    end else if (wr_win) begin
      window <= wdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= READ_NONE;
    end else if (rd) begin
      case (addr)
        CTRL_ADDR: rdata <= {watchdog_activate, count};
        WIN_ADDR:  rdata <= {1'b0, window};
        default:   rdata <= READ_NONE;
      endcase
    end else begin
      rdata <= READ_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin driver
  // ----------------------------------------------------------------
  // The only output besides registers; no interrupt exists
  reset_pulse u_pulse (
    .clk      (clk),
    .nrst     (nrst),
    .start    (trigger),
    .pin_out  (rst_pin_out),
    .pin_oe_n (rst_pin_oe_n),
    .busy     (pulse_busy)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Tick without reload takes exactly one off
  tick_dec_a: assert property (
    tick && !wr_ctrl |=> count == count_dec($past(count)))
    else $error("count did not drop on tick");

  // Rollover pulls the pin low shortly after
  rollover_rst_a: assert property (
    rollover && !pulse_busy |-> ##[1:2] !rst_pin_oe_n)
    else $error("rollover gave no reset");

  // Top bit clears after an active rollover
  top_bit_fall_a: assert property (
    rollover |=> !count_top_bit)
    else $error("top bit still set after rollover");

  // Early reload: reset and the count is not replaced
  early_rst_a: assert property (
    early_reload && !pulse_busy |-> ##1 !rst_pin_oe_n ##0
      (count != $past(wdata[6:0]) || $past(count) == $past(wdata[6:0])
       || $past(tick)))
    else $error("early reload not punished");

  // Without activation nothing but halt may fire
  quiet_idle_a: assert property (
    !active && !halt_trig && !pulse_busy |=> rst_pin_oe_n)
    else $error("inactive watchdog fired");

  // Activation never falls outside reset
  act_sticky_a: assert property (
    watchdog_activate |=> watchdog_activate)
    else $error("activate bit cleared");

  // Hardware option keeps the watchdog live
  hw_mode_a: assert property (
    hw_act && tick && !wr_ctrl && count == COUNT_THRESH && !pulse_busy
      |-> ##[1:2] !rst_pin_oe_n)
    else $error("hardware watchdog did not fire");

  // Halt with the option set resets
  halt_rst_a: assert property (
    halt_trig && !pulse_busy |-> ##[1:2] !rst_pin_oe_n)
    else $error("halt gave no reset");

  // Accepted reload lands next cycle
  reload_take_a: assert property (
    wr_ctrl && !early_reload |=> count == $past(wdata[6:0]))
    else $error("reload not taken");

  // Control read shows bit and count
  ctrl_read_a: assert property (
    rd && addr == CTRL_ADDR
      |=> rdata == {$past(watchdog_activate), $past(count)})
    else $error("control read wrong");

  // Window write stored, bit 7 reads zero
  win_store_a: assert property (
    wr_win |=> ##1 !$past(rd) || $past(addr) != WIN_ADDR ||
      rdata == {1'b0, window})
    else $error("window store wrong");

  // Read data vanish after one cycle
  read_hold_a: assert property (
    !rd |=> rdata == READ_NONE)
    else $error("read data held too long");

  // ----------------------------------------------------------------
  // Checks on registers, options and the pin
  // ----------------------------------------------------------------
  // Pin value stays low; the pull-up alone makes the high level
  pin_low_only_a: assert property (
    rst_pin_out == 1'b0)
    else $error("reset pin driven high");

  // Tick-free, write-free cycles leave the count alone
  count_hold_a: assert property (
    !tick && !wr_ctrl |=> count == $past(count))
    else $error("count moved without tick");

  // Rollover at the threshold steps down and pulls the pin
  threshold_step_a: assert property (
    active && tick && !wr_ctrl && count == COUNT_THRESH && !pulse_busy
      |=> !rst_pin_oe_n && count == count_dec(COUNT_THRESH))
    else $error("threshold rollover missed");

  // Window left alone unless written
  window_hold_a: assert property (
    !wr_win |=> window == $past(window))
    else $error("window changed unwritten");

  // Window read shows seven bits under a zero
  win_read_a: assert property (
    rd && addr == WIN_ADDR
      |=> rdata == {1'b0, $past(window)})
    else $error("window read wrong");

  // Unmapped indices read as zero
  unmapped_read_a: assert property (
    rd && addr != CTRL_ADDR && addr != WIN_ADDR
      |=> rdata == READ_NONE)
    else $error("unmapped read not zero");

  // Reload inside the window raises no reset
  good_reload_quiet_a: assert property (
    wr_ctrl && count <= window && !halt_trig && !pulse_busy
      |=> rst_pin_oe_n)
    else $error("good reload gave reset");

  // Hardware option punishes an early reload too
  early_hw_a: assert property (
    hw_act && wr_ctrl && count > window && !pulse_busy
      |=> !rst_pin_oe_n)
    else $error("early reload passed in hardware mode");

  // A set bit in a control write arms the watchdog
  act_set_a: assert property (
    wr_ctrl && wdata[ACT_BIT] |=> watchdog_activate)
    else $error("activate bit not set");

  // Nothing but a control write sets the activate bit
  act_hold_low_a: assert property (
    !watchdog_activate && !(wr_ctrl && wdata[ACT_BIT])
      |=> !watchdog_activate)
    else $error("activate bit set by itself");

  // Accepted or inactive reload takes the written count
  count_reload_a: assert property (
    wr_ctrl && (!active || count <= window)
      |=> count == $past(wdata[6:0]))
    else $error("reload value lost");

  // Options copied once, on the first edge after release
  opt_first_a: assert property (
    $rose(opt_taken) |-> hw_act == $past(opt_hw_activate) &&
      halt_rst == $past(opt_halt_reset))
    else $error("options not sampled");

  // Options never change after they are taken
  opt_frozen_a: assert property (
    opt_taken |=> hw_act == $past(hw_act) && halt_rst == $past(halt_rst))
    else $error("options changed in run");

  // Halt without the option leaves the pin alone
  halt_off_a: assert property (
    halt_exec && !halt_rst && !active && !pulse_busy |=> rst_pin_oe_n)
    else $error("halt reset without option");

  // Top bit reads back through the control register
  top_bit_read_a: assert property (
    rd && addr == CTRL_ADDR |=> rdata[TOP_BIT] == $past(count_top_bit))
    else $error("top bit read wrong");

  // Main scenarios
  rollover_c: cover property (rollover);
  early_c:    cover property (early_reload);
  good_reload_c: cover property (
    wr_ctrl && active && !early_reload);
  halt_c:     cover property (halt_trig);
  // Hardware-activated rollover, with the software bit clear
  hw_c:       cover property (hw_act && !watchdog_activate && rollover);

endmodule

/* File: reset_line_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// System reset line: open drain with a pull-up
// ----------------------------------------------------------------
module reset_line_model (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      line,
  output logic      pulse_end,
  output int        low_len,
  output int        pulses
);
  int run;

  // Pull-up wins whenever the pin is released
  assign line = pin_oe_n ? 1'b1 : pin_out;

  // Low stretch measured in clock samples, reported as it ends
  always @(posedge clk) begin
    pulse_end <= 1'b0;
    if (line === 1'b0) begin
      if (run == 0) pulses <= pulses + 1;
      run <= run + 1;
    end else if (run != 0) begin
      low_len   <= run;
      pulse_end <= 1'b1;
      run       <= 0;
    end
  end
endmodule

/* File: window_watchdog_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module window_watchdog_tb_top
  import window_watchdog_pkg::*;
;
  // Short tick keeps each rollover a few dozen cycles away
  localparam int TICKS = 16;
  logic       clk, nrst, wr, rd, opt_hw_activate, opt_halt_reset, halt_exec;
  logic [7:0] addr, wdata, rdata, v, e8;
  logic       rst_pin_out, rst_pin_oe_n, line, pulse_end, rd_seen;
  int         low_len, pulses, err_total, samples_checked, cyc, rel, seed, t0, t1, n0, e32;
  logic [7:0] rd_q[$];
  int         pulse_q[$];

  window_watchdog #(.TICK_CYCLES(TICKS)) window_watchdog_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .opt_hw_activate(opt_hw_activate), .opt_halt_reset(opt_halt_reset), .halt_exec(halt_exec),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n));
  reset_line_model reset_line_model_i (
    .clk(clk), .pin_out(rst_pin_out), .pin_oe_n(rst_pin_oe_n), .line(line),
    .pulse_end(pulse_end), .low_len(low_len), .pulses(pulses));

  // ----------------------------------------------------------------
  // Clock and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic give_up;
    err_total++;
    test_done();
  endtask

  // ----------------------------------------------------------------
  // Drivers: register port, reset, halt
  // ----------------------------------------------------------------
  // Options change only under reset, as the part samples them once
  task automatic do_reset(input logic hw, input logic hlt);
    @(posedge clk);
    nrst            <= 1'b0;
    opt_hw_activate <= hw;
    opt_halt_reset  <= hlt;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rel = cyc;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Expected read data queued before the strobe leaves
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic halt_once;
    @(posedge clk);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
  endtask

  // Pulse start within bound cycles; start time relative to release
  task automatic expect_pulse(input int bound, output int t);
    int i;
    pulse_q.push_back(PULSE_CYCLES);
    for (i = 0; i < bound && line !== 1'b0; i++) @(posedge clk);
    if (i == bound) give_up();
    t = cyc - rel;
    for (i = 0; i < 800 && pulse_q.size() != 0; i++) @(posedge clk);
    if (i == 800) give_up();
  endtask

  task automatic no_pulse(input int n);
    n0 = pulses;
    repeat (n) @(posedge clk);
    `CHK(pulses - n0, 0)
  endtask

  // ----------------------------------------------------------------
  // Watcher: read data and finished pulses against the notes
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_seen && rd_q.size() != 0) begin
      e8 = rd_q.pop_front();
      `CHK(rdata, e8)
    end
    rd_seen <= rd;
    if (pulse_end && pulse_q.size() != 0) begin
      e32 = pulse_q.pop_front();
      `CHK(low_len, e32)
    end
  end

  // ----------------------------------------------------------------
  // Scenarios, each starting from a fresh reset
  // ----------------------------------------------------------------
  initial begin
    {nrst, wr, rd, opt_hw_activate, opt_halt_reset, halt_exec} = '0;
    {addr, wdata} = '0;
    seed = 51;
    {err_total, samples_checked, rel} = '0;
    do_reset(1'b0, 1'b0);
    rd_reg(CTRL_ADDR, CTRL_RESET);
    rd_reg(WIN_ADDR, WIN_RESET);
    wr_reg(8'h02, 8'h00);
    rd_reg(8'h02, READ_NONE);
    rd_reg(CTRL_ADDR, CTRL_RESET);
    v = 8'($random(seed));
    wr_reg(WIN_ADDR, v);
    rd_reg(WIN_ADDR, {1'b0, v[6:0]});
    $display("Test reset_values done");
    // Inactive: neither early reload nor rollover may reset
    do_reset(1'b0, 1'b0);
    wr_reg(WIN_ADDR, 8'h10);
    wr_reg(CTRL_ADDR, 8'h41);
    rd_reg(CTRL_ADDR, 8'h41);
    no_pulse(4 * TICKS);
    $display("Test inactive done");
    // One extra count step delays the rollover by one tick
    do_reset(1'b0, 1'b0);
    wr_reg(CTRL_ADDR, 8'hC0);
    expect_pulse(3 * TICKS, t0);
    do_reset(1'b0, 1'b0);
    wr_reg(CTRL_ADDR, 8'hC1);
    expect_pulse(3 * TICKS, t1);
    `CHK(t1 - t0, TICKS)
    $display("Test rollover done");
    // Reload above the window is refused and resets
    do_reset(1'b0, 1'b0);
    wr_reg(WIN_ADDR, 8'h50);
    wr_reg(CTRL_ADDR, 8'hF0);
    wr_reg(CTRL_ADDR, 8'hE0);
    rd_reg(CTRL_ADDR, 8'hF0);
    expect_pulse(10, t0);
    $display("Test early_reload done");
    // Writing zero to activation keeps the watchdog armed
    do_reset(1'b0, 1'b0);
    wr_reg(CTRL_ADDR, 8'hC5);
    wr_reg(CTRL_ADDR, 8'h45);
    rd_reg(CTRL_ADDR, 8'hC5);
    expect_pulse(10 * TICKS, t0);
    $display("Test sticky_activate done");
    do_reset(1'b1, 1'b0);
    wr_reg(CTRL_ADDR, 8'h40);
    expect_pulse(3 * TICKS, t0);
    $display("Test hw_activate done");
    do_reset(1'b0, 1'b1);
    halt_once();
    expect_pulse(10, t0);
    do_reset(1'b0, 1'b0);
    halt_once();
    no_pulse(TICKS / 2);
    $display("Test halt done");
    test_done();
  end
endmodule
